/* File: hdl/ubdsl_map.svh */
// register offsets, field positions, reset values and limits of the serial support block
`ifndef UBDSL_MAP_SVH
`define UBDSL_MAP_SVH

`define UBDSL_ADDR_W          4
`define UBDSL_OFF_DIV_LOW     4'h0
`define UBDSL_OFF_DIV_HIGH    4'h1
`define UBDSL_OFF_INT_EN      4'h2
`define UBDSL_OFF_FIFO_CTRL   4'h3
`define UBDSL_OFF_MODEM_CTRL  4'h4
`define UBDSL_OFF_MODEM_STAT  4'h5
`define UBDSL_OFF_ENH_FEAT    4'h6
`define UBDSL_OFF_STATUS      4'h7

`define UBDSL_FCR_DMA_BIT     3
`define UBDSL_IER_SLEEP_BIT   4
`define UBDSL_EFR_ENH_BIT     4
`define UBDSL_MCR_DTR_BIT     0
`define UBDSL_MCR_RTS_BIT     1
`define UBDSL_MCR_AUX1_BIT    2
`define UBDSL_MCR_AUX2_BIT    3
`define UBDSL_MCR_LOOP_BIT    4

`define UBDSL_RST_BYTE        8'h00
`define UBDSL_RST_DIV         16'h0001
`define UBDSL_RST_CNT         16'h0000
`define UBDSL_ONE_DIV         16'h0001
`define UBDSL_UNMAPPED        8'h00
`define UBDSL_MARK            1'b1
`define UBDSL_MODEM_IDLE      4'hf
`define UBDSL_SYNC_IDLE       6'h1f

`endif

/* File: hdl/ubdsl_pkg.sv */
// types shared by the serial support block
package ubdsl_pkg;

    // modem inputs as seen inside: cts, dsr, ri, dcd (active high)
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ubdsl_modem_t;

    // fifo status from the data path
    typedef struct packed {
        logic rx_empty;
        logic rx_trigger;
        logic rx_timeout;
        logic tx_empty;
        logic tx_full;
    } ubdsl_fifo_t;

    typedef enum logic [1:0] {
        UBDSL_AWAKE    = 2'b00,
        UBDSL_DRAINING = 2'b01,
        UBDSL_ASLEEP   = 2'b11
    } ubdsl_sleep_t;

endpackage

/* File: hdl/ubdsl_top.sv */
// baud generator, dma ready pins, sleep control and loop-back of the serial port
//
// Function
// [R1] divisor 1 to 65535 divides input clock into 16x sampling tick
// [R2] baud clock output toggles at sixteen times the bit rate
// [R3] host writes divisor high and low bytes; divisor = clock / (16 * rate)
// [R4] one baud tick feeds both transmitter and receiver
// [R5] input clock may run up to 48 MHz
// [R6] fifo control bit 3 selects dma mode for both ready pins
// [R7] non-dma: rx ready high when rx fifo empty, low otherwise
// [R8] dma: rx ready falls on trigger or timeout, rises when empty
// [R9] non-dma: tx ready high when tx fifo holds data, low empty
// [R10] dma: tx ready high when tx fifo full, low otherwise
// [R11] sleep needs enhanced bit 4 and interrupt enable bit 4 set
// [R12] start bit, rx or modem change, or tx data wakes device
// [R13] device sleeps again after last character sent or read
// [R14] sleep never entered while an interrupt is pending
// [R15] sleep stays enabled until interrupt enable bit 4 cleared; code also ends it when enhanced bit 4 cleared
// [R16] loop-back joins tx to rx internally, away from pins
// [R17] loop-back: aux one drives ri, aux two drives dcd
// [R18] loop-back: dtr drives cts, rts drives dsr, pins ignored
// [R19] loop-back: modem changes seen in low four status bits
// [R20] modem control bit 4 selects loop-back; serial out idles mark
`timescale 1ns/10ps
`default_nettype none
`include "ubdsl_map.svh"

module ubdsl_top
    import ubdsl_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    input  wire logic [`UBDSL_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_write,
    input  wire logic                     reg_read,
    output logic      [7:0]               reg_rdata,
    input  wire logic                     osc_input,
    input  wire ubdsl_fifo_t              fifo_stat,
    input  wire logic                     int_pending,
    input  wire logic                     tx_data_write,
    input  wire logic                     rx_data_read,
    input  wire logic                     tx_busy,
    input  wire logic                     rx_start_bit,
    input  wire logic                     tx_serial,
    output logic                          rx_serial,
    input  wire logic                     serial_in_pin,
    output logic                          serial_out_pin,
    input  wire logic [3:0]               modem_pins_n,
    output logic                          dtr_pin_n,
    output logic                          rts_pin_n,
    output logic                          baud_tick,
    output logic                          baud_clock_out,
    output logic                          rx_ready_pin,
    output logic                          tx_ready_pin,
    output logic                          sleep_active,
    output logic      [3:0]               modem_status_reg
);

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    logic [7:0]   divisor_low_byte_r;
    logic [7:0]   divisor_high_byte_r;
    logic [7:0]   interrupt_enable_reg_r;
    logic [7:0]   fifo_control_reg_r;
    logic [7:0]   modem_control_reg_r;
    logic [7:0]   enhanced_feature_reg_r;
    logic [3:0]   delta_r;
    logic [7:0]   rdata_nxt;

    // [R3] divisor byte writes
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            divisor_low_byte_r  <= 8'(`UBDSL_RST_DIV);
            divisor_high_byte_r <= `UBDSL_RST_BYTE;
        end
        else if (reg_write && reg_addr == `UBDSL_OFF_DIV_LOW)
            divisor_low_byte_r  <= reg_wdata;
        else if (reg_write && reg_addr == `UBDSL_OFF_DIV_HIGH)
            divisor_high_byte_r <= reg_wdata;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            interrupt_enable_reg_r <= `UBDSL_RST_BYTE;
            fifo_control_reg_r     <= `UBDSL_RST_BYTE;
            modem_control_reg_r    <= `UBDSL_RST_BYTE;
            enhanced_feature_reg_r <= `UBDSL_RST_BYTE;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                `UBDSL_OFF_INT_EN:     interrupt_enable_reg_r <= reg_wdata;
                `UBDSL_OFF_FIFO_CTRL:  fifo_control_reg_r     <= reg_wdata;
                `UBDSL_OFF_MODEM_CTRL: modem_control_reg_r    <= reg_wdata;
                `UBDSL_OFF_ENH_FEAT:   enhanced_feature_reg_r <= reg_wdata;
                default:               ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= `UBDSL_SYNC_IDLE;
            sync2_r <= `UBDSL_SYNC_IDLE;
        end
        else
        begin
            sync1_r <= {osc_input, serial_in_pin, modem_pins_n};
            sync2_r <= sync1_r;
        end
    end

    logic       osc_s;
    logic       rx_pin_s;
    logic [3:0] modem_n_s;
    assign osc_s     = sync2_r[5];
    assign rx_pin_s  = sync2_r[4];
    assign modem_n_s = sync2_r[3:0];

    // -----------------------------------------------------------------
    // baud generator
    // -----------------------------------------------------------------
    logic [15:0] divisor;
    logic [15:0] baud_cnt_r;
    logic        osc_d_r;
    logic        osc_rise;

    assign divisor  = {divisor_high_byte_r, divisor_low_byte_r};
    // [R5] oscillator rate limited by sampling
    assign osc_rise = osc_s && !osc_d_r;

    // [R1] divide by programmed divisor
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            osc_d_r    <= 1'b0;
            baud_cnt_r <= `UBDSL_RST_CNT;
            baud_tick  <= 1'b0;
        end
        else
        begin
            osc_d_r   <= osc_s;
            baud_tick <= 1'b0;
            if (osc_rise)
            begin
                if (baud_cnt_r + `UBDSL_ONE_DIV >= divisor)
                begin
                    baud_cnt_r <= `UBDSL_RST_CNT;
                    // [R4] one shared tick
                    baud_tick  <= 1'b1;
                end
                else
                    baud_cnt_r <= baud_cnt_r + `UBDSL_ONE_DIV;
            end
        end
    end

    // [R2] 16x clock output
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            baud_clock_out <= 1'b0;
        else
            baud_clock_out <= baud_tick ? 1'b1 :
                              (osc_rise ? 1'b0 : baud_clock_out);
    end

    // -----------------------------------------------------------------
    // dma ready pins
    // -----------------------------------------------------------------
    logic dma_mode;
    // [R6] dma select
    assign dma_mode = fifo_control_reg_r[`UBDSL_FCR_DMA_BIT];

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            rx_ready_pin <= 1'b1;
        else if (!dma_mode)
            // [R7] level follows empty
            rx_ready_pin <= fifo_stat.rx_empty;
        else if (fifo_stat.rx_trigger || fifo_stat.rx_timeout)
            // [R8] fall on trigger
            rx_ready_pin <= 1'b0;
        else if (fifo_stat.rx_empty)
            rx_ready_pin <= 1'b1;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            tx_ready_pin <= 1'b0;
        else if (!dma_mode)
            // [R9] high with data
            tx_ready_pin <= !fifo_stat.tx_empty;
        else
            // [R10] high when full
            tx_ready_pin <= fifo_stat.tx_full;
    end

    // -----------------------------------------------------------------
    // loop-back and modem inputs
    // -----------------------------------------------------------------
    logic         loop_mode;
    ubdsl_modem_t modem_int;
    ubdsl_modem_t modem_d_r;

    // [R20] loop-back select
    assign loop_mode = modem_control_reg_r[`UBDSL_MCR_LOOP_BIT];

    always_comb
    begin
        if (loop_mode)
        begin
            // [R18] dtr to cts, rts to dsr
            modem_int.cts = modem_control_reg_r[`UBDSL_MCR_DTR_BIT];
            modem_int.dsr = modem_control_reg_r[`UBDSL_MCR_RTS_BIT];
            // [R17] aux outputs to ri and dcd
            modem_int.ri  = modem_control_reg_r[`UBDSL_MCR_AUX1_BIT];
            modem_int.dcd = modem_control_reg_r[`UBDSL_MCR_AUX2_BIT];
        end
        else
            modem_int = ~modem_n_s;
    end

    // [R16] internal serial path
    assign rx_serial = loop_mode ? tx_serial : rx_pin_s;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            serial_out_pin <= `UBDSL_MARK;
            dtr_pin_n      <= 1'b1;
            rts_pin_n      <= 1'b1;
        end
        else
        begin
            // [R20] serial out idles at mark
            serial_out_pin <= loop_mode ? `UBDSL_MARK : tx_serial;
            dtr_pin_n <= loop_mode | ~modem_control_reg_r[`UBDSL_MCR_DTR_BIT];
            rts_pin_n <= loop_mode | ~modem_control_reg_r[`UBDSL_MCR_RTS_BIT];
        end
    end

    // [R19] change flags in low status bits, set wins over read clear
    logic rd_stat;
    assign rd_stat = reg_read && reg_addr == `UBDSL_OFF_MODEM_STAT;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            modem_d_r <= '0;
            delta_r   <= 4'h0;
        end
        else
        begin
            modem_d_r <= modem_int;
            delta_r   <= (rd_stat ? 4'h0 : delta_r) | (modem_int ^ modem_d_r);
        end
    end
    assign modem_status_reg = delta_r;

    // -----------------------------------------------------------------
    // sleep control
    // -----------------------------------------------------------------
    ubdsl_sleep_t sleep_r;
    logic         sleep_en;
    logic         wake;
    logic         idle;
    logic         rx_d_r;
    logic [3:0]   modem_pin_d_r;

    // [R11] both enables needed; [R15] held until either bit cleared
    assign sleep_en = enhanced_feature_reg_r[`UBDSL_EFR_ENH_BIT]
                    & interrupt_enable_reg_r[`UBDSL_IER_SLEEP_BIT];
    // [R12] wake sources
    assign wake = rx_start_bit || tx_data_write || (rx_pin_s != rx_d_r)
                || (modem_n_s != modem_pin_d_r);
    // [R13] drained when nothing to send or read
    assign idle = !tx_busy && fifo_stat.tx_empty && fifo_stat.rx_empty;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_d_r        <= `UBDSL_MARK;
            modem_pin_d_r <= `UBDSL_MODEM_IDLE;
        end
        else
        begin
            rx_d_r        <= rx_pin_s;
            modem_pin_d_r <= modem_n_s;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            sleep_r <= UBDSL_AWAKE;
        else if (!sleep_en)
            sleep_r <= UBDSL_AWAKE;
        else
        begin
            case (sleep_r)
                UBDSL_AWAKE:    sleep_r <= UBDSL_DRAINING;
                UBDSL_DRAINING:
                    // [R14] no sleep with interrupt pending
                    if (idle && !int_pending && !wake)
                        sleep_r <= UBDSL_ASLEEP;
                UBDSL_ASLEEP:
                    if (wake)
                        sleep_r <= UBDSL_DRAINING;
                default:        sleep_r <= UBDSL_AWAKE;
            endcase
        end
    end
    assign sleep_active = (sleep_r == UBDSL_ASLEEP);

    // -----------------------------------------------------------------
    // register read port
    // -----------------------------------------------------------------
    always_comb
    begin
        case (reg_addr)
            `UBDSL_OFF_DIV_LOW:    rdata_nxt = divisor_low_byte_r;
            `UBDSL_OFF_DIV_HIGH:   rdata_nxt = divisor_high_byte_r;
            `UBDSL_OFF_INT_EN:     rdata_nxt = interrupt_enable_reg_r;
            `UBDSL_OFF_FIFO_CTRL:  rdata_nxt = fifo_control_reg_r;
            `UBDSL_OFF_MODEM_CTRL: rdata_nxt = modem_control_reg_r;
            `UBDSL_OFF_MODEM_STAT: rdata_nxt = {modem_int, delta_r};
            `UBDSL_OFF_ENH_FEAT:   rdata_nxt = enhanced_feature_reg_r;
            `UBDSL_OFF_STATUS:     rdata_nxt = {4'h0, sleep_active, dma_mode,
                                                rx_ready_pin, tx_ready_pin};
            default:               rdata_nxt = `UBDSL_UNMAPPED;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= `UBDSL_UNMAPPED;
        else if (reg_read)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= `UBDSL_UNMAPPED;
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    AST_NODMA_RX: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
        !dma_mode && !$past(dma_mode) |-> rx_ready_pin == $past(fifo_stat.rx_empty))
        else $error("rx ready does not follow fifo empty");
    AST_DMA_RX_FALL: assert property (@(posedge sys_clk) disable iff (reset) // [R8]
        dma_mode && (fifo_stat.rx_trigger || fifo_stat.rx_timeout) |=> !rx_ready_pin)
        else $error("rx ready did not fall on trigger");
    AST_NODMA_TX: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
        !dma_mode && fifo_stat.tx_empty |=> !tx_ready_pin)
        else $error("tx ready high with empty fifo");
    AST_DMA_TX: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
        dma_mode && fifo_stat.tx_full |=> tx_ready_pin)
        else $error("tx ready low with full fifo");
    AST_SLEEP_EN: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
        sleep_active |-> $past(sleep_en))
        else $error("asleep without both enables");
    AST_WAKE: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
        sleep_active && tx_data_write |=> !sleep_active)
        else $error("tx data did not wake");
    AST_NO_SLEEP_INT: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
        !sleep_active && int_pending |=> !sleep_active)
        else $error("slept with interrupt pending");
    AST_LOOP_OUT: assert property (@(posedge sys_clk) disable iff (reset) // [R20]
        loop_mode [*2] |-> serial_out_pin == `UBDSL_MARK)
        else $error("serial out not at mark in loop-back");
    AST_LOOP_CTS: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
        loop_mode && $stable(modem_control_reg_r) |-> $stable(modem_int))
        else $error("modem pins reach status in loop-back");
    AST_BAUD_DIV1: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
        divisor == `UBDSL_ONE_DIV && osc_rise |=> baud_tick)
        else $error("divide by one missed a tick");

endmodule // ubdsl_top

`default_nettype wire

/* File: test/ubdsl_host_model.sv */
// host processor model: register bus master of the serial support block
`timescale 1ns/10ps
`default_nettype none
`include "ubdsl_map.svh"

module ubdsl_host_model
    import ubdsl_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [3:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_write,
    output var  logic       reg_read,
    output var  logic       tx_data_write
);
    initial
    begin
        reg_addr      = 4'h0;
        reg_wdata     = 8'h00;
        reg_write     = 1'b0;
        reg_read      = 1'b0;
        tx_data_write = 1'b0;
    end

    // released address and data show the inverse, never the last value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    task automatic set_div(input logic [15:0] v);
        wr(`UBDSL_OFF_DIV_HIGH, v[15:8]);
        wr(`UBDSL_OFF_DIV_LOW, v[7:0]);
    endtask

    task automatic put_tx;
        @(posedge sys_clk);
        tx_data_write <= 1'b1;
        @(posedge sys_clk);
        tx_data_write <= 1'b0;
    endtask
endmodule // ubdsl_host_model
`default_nettype wire

/* File: test/test_ubdsl_top.sv */
// self-checking bench of the serial support block
`timescale 1ns/10ps
`default_nettype none
`include "ubdsl_map.svh"

module test_ubdsl_top
    import ubdsl_pkg::*;
;
    logic        sys_clk, reset, reg_write, reg_read, tx_data_write, osc_input;
    logic [3:0]  reg_addr, modem_pins_n, modem_status_reg;
    logic [7:0]  reg_wdata, reg_rdata;
    ubdsl_fifo_t fifo_stat;
    logic        int_pending, rx_data_read, tx_busy, rx_start_bit, tx_serial;
    logic        serial_in_pin, rx_serial, serial_out_pin, dtr_pin_n, rts_pin_n;
    logic        baud_tick, baud_clock_out, rx_ready_pin, tx_ready_pin, sleep_active;
    logic [1:0]  osc_cnt;
    int          n_fail, cmp_count;

    ubdsl_top ubdsl_top_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .osc_input(osc_input), .fifo_stat(fifo_stat),
        .int_pending(int_pending), .tx_data_write(tx_data_write),
        .rx_data_read(rx_data_read), .tx_busy(tx_busy), .rx_start_bit(rx_start_bit),
        .tx_serial(tx_serial), .rx_serial(rx_serial), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .modem_pins_n(modem_pins_n),
        .dtr_pin_n(dtr_pin_n), .rts_pin_n(rts_pin_n), .baud_tick(baud_tick),
        .baud_clock_out(baud_clock_out), .rx_ready_pin(rx_ready_pin),
        .tx_ready_pin(tx_ready_pin), .sleep_active(sleep_active),
        .modem_status_reg(modem_status_reg));

    ubdsl_host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .tx_data_write(tx_data_write));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // oscillator at a quarter of the system clock
    always @(posedge sys_clk)
    begin
        osc_cnt   <= osc_cnt + 2'd1;
        osc_input <= osc_cnt[1];
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic sleep_within(input logic want, input int lim);
        int k;
        k = 0;
        while (sleep_active !== want && k < lim)
        begin
            @(negedge sys_clk);
            k++;
        end
        check("sleep_active", sleep_active, want);
    endtask

    // cycles between two rises of the tick (w=0) or the baud clock (w=1)
    task automatic period(input int w, output int n);
        int k;
        n = 0;
        for (k = 0; k < 2; k++)
        begin
            while ((w ? baud_clock_out : baud_tick) !== 1'b0 && n < 9000)
            begin
                @(negedge sys_clk);
                n++;
            end
            while ((w ? baud_clock_out : baud_tick) !== 1'b1 && n < 9000)
            begin
                @(negedge sys_clk);
                n++;
            end
            if (k == 0)
                n = 0;
        end
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    task automatic test_regs;
        logic [7:0] d;
        logic [7:0] v;
        int offs[5] = '{0, 1, 2, 3, 6};
        int a;
        for (a = 0; a < 16; a++)
        begin
            host.rd(a[3:0], d);
            check("reset value", d, (a == 0) ? 8'h01 : (a == 7) ? 8'h02 : 8'h00);
        end
        foreach (offs[a])
        begin
            v = 8'($urandom);
            host.wr(offs[a][3:0], v);
            host.rd(offs[a][3:0], d);
            check("read back", d, v);
            host.wr(offs[a][3:0], 8'h00);
        end
        host.wr(`UBDSL_OFF_STATUS, 8'hff);
        host.rd(`UBDSL_OFF_STATUS, d);
        check("read only status", d, 8'h02);
        $display("test regs done");
    endtask

    task automatic test_baud;
        logic [15:0] div;
        int i, n;
        for (i = 0; i < 5; i++)
        begin
            div = (i == 3) ? 16'h0102 : (i == 4) ? 16'h0001 : 16'($urandom_range(9, 2));
            host.set_div(div);
            period(0, n);
            period(0, n);
            check("tick gap", 16'(n), 16'(4 * div));
            if (i < 4)
            begin
                period(1, n);
                check("baud clock period", 16'(n), 16'(4 * div));
            end
        end
        $display("test baud done");
    endtask

    task automatic test_ready;
        logic [31:0] r;
        logic [7:0]  d;
        logic        rxm, txm;
        int          m, i;
        for (m = 0; m < 2; m++)
        begin
            @(posedge sys_clk);
            fifo_stat <= ubdsl_fifo_t'(5'b10010);
            host.wr(`UBDSL_OFF_FIFO_CTRL, m ? 8'h08 : 8'h00);
            cyc(2);
            rxm = 1'b1;
            for (i = 0; i < 40; i++)
            begin
                r = $urandom;
                @(posedge sys_clk);
                fifo_stat <= ubdsl_fifo_t'({r[0], ~r[0] & r[1], ~r[0] & r[2], r[3], ~r[3] & r[4]});
                @(posedge sys_clk);
                @(negedge sys_clk);
                if (m == 0 || r[0])
                    rxm = r[0];
                else if (r[1] | r[2])
                    rxm = 1'b0;
                txm = m ? (~r[3] & r[4]) : ~r[3];
                check("rx ready", rx_ready_pin, rxm);
                check("tx ready", tx_ready_pin, txm);
            end
            host.rd(`UBDSL_OFF_STATUS, d);
            check("dma mode bit", d[2], m[0]);
        end
        @(posedge sys_clk);
        fifo_stat <= ubdsl_fifo_t'(5'b10010);
        host.wr(`UBDSL_OFF_FIFO_CTRL, 8'h00);
        $display("test ready done");
    endtask

    task automatic test_sleep;
        int k;
        host.wr(`UBDSL_OFF_INT_EN, 8'h10);
        cyc(10);
        check("sleep without enhanced", sleep_active, 1'b0);
        int_pending <= 1'b1;
        host.wr(`UBDSL_OFF_ENH_FEAT, 8'h10);
        cyc(10);
        check("sleep with interrupt", sleep_active, 1'b0);
        int_pending <= 1'b0;
        sleep_within(1'b1, 8);
        for (k = 0; k < 4; k++)
        begin
            @(posedge sys_clk);
            case (k)
                0: rx_start_bit <= 1'b1;
                1: serial_in_pin <= ~serial_in_pin;
                2: modem_pins_n[1] <= ~modem_pins_n[1];
                default: rx_start_bit <= 1'b0;
            endcase
            if (k[0])
                tx_busy <= 1'b1;
            else
                fifo_stat.rx_empty <= 1'b0;
            @(posedge sys_clk);
            rx_start_bit <= 1'b0;
            if (k == 3)
                host.put_tx();
            sleep_within(1'b0, 8);
            cyc(20);
            check("asleep while busy", sleep_active, 1'b0);
            tx_busy <= 1'b0;
            fifo_stat.rx_empty <= 1'b1;
            rx_data_read <= ~k[0];
            @(posedge sys_clk);
            rx_data_read <= 1'b0;
            sleep_within(1'b1, 8);
        end
        host.wr(`UBDSL_OFF_INT_EN, 8'h00);
        sleep_within(1'b0, 8);
        cyc(10);
        check("sleep after disable", sleep_active, 1'b0);
        host.wr(`UBDSL_OFF_ENH_FEAT, 8'h00);
        $display("test sleep done");
    endtask

    task automatic test_loop;
        logic [7:0] d;
        int i;
        host.wr(`UBDSL_OFF_MODEM_CTRL, 8'h03);
        tx_serial <= 1'b0;
        cyc(4);
        check("modem pins normal", {dtr_pin_n, rts_pin_n}, 2'b00);
        check("serial out normal", serial_out_pin, 1'b0);
        check("rx from pin", rx_serial, serial_in_pin);
        host.wr(`UBDSL_OFF_MODEM_CTRL, 8'h13);
        cyc(2);
        check("pins in loop-back", {serial_out_pin, dtr_pin_n, rts_pin_n}, 3'b111);
        for (i = 0; i < 2; i++)
        begin
            @(posedge sys_clk);
            tx_serial <= i[0];
            serial_in_pin <= ~i[0];
            @(negedge sys_clk);
            check("rx from tx", rx_serial, i[0]);
        end
        for (i = 0; i < 4; i++)
        begin
            host.wr(`UBDSL_OFF_MODEM_CTRL, 8'h10);
            cyc(4);
            host.rd(`UBDSL_OFF_MODEM_STAT, d);
            host.wr(`UBDSL_OFF_MODEM_CTRL, 8'h10 | (8'h01 << i));
            modem_pins_n <= 4'($urandom);
            cyc(4);
            check("change flags", modem_status_reg, 4'h1 << i);
            host.rd(`UBDSL_OFF_MODEM_STAT, d);
            check("modem status", d, {4'h1 << i, 4'h1 << i});
        end
        host.wr(`UBDSL_OFF_MODEM_CTRL, 8'h00);
        $display("test loop done");
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        $display("watchdog expired");
        give_verdict();
    end

    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        reset = 1'b1;
        osc_cnt = 2'd0;
        osc_input = 1'b0;
        fifo_stat = ubdsl_fifo_t'(5'b10010);
        {int_pending, rx_data_read, tx_busy, rx_start_bit} = 4'h0;
        tx_serial = 1'b1;
        serial_in_pin = 1'b1;
        modem_pins_n = 4'hf;
        void'($urandom(32'hd893));
        cyc(10);
        reset <= 1'b0;
        test_regs();
        test_baud();
        test_ready();
        test_sleep();
        test_loop();
        give_verdict();
    end
endmodule // test_ubdsl_top
`default_nettype wire
